// ===== core/sarc_conv_if.sv
// link between the control logic and the SAR sequencer
// assumes both ends run on the same aclk
`timescale 1ns/1ns
`default_nettype none
interface sarc_conv_if;
  logic              go;
  logic              eight;
  logic [4:0]        div;
  logic              cmp;
  logic              busy;
  logic              done;
  logic [9:0]        code;
  logic [9:0]        trial;
  logic              sample;
  modport ctl  (output go, eight, div, cmp,
                input  busy, done, code, trial, sample);
  modport core (input  go, eight, div, cmp,
                output busy, done, code, trial, sample);
endinterface
`default_nettype wire

// ===== core/sarc_pkg.sv
// constants, register map and types of the converter control block
// assumes a single aclk domain and a 32-bit AXI4-Lite register bus
package sarc_pkg;
  localparam int CODE_W = 10;
  localparam int ACC_W  = 16;
  localparam int ADDR_W = 8;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CFG    = 8'h04;
  localparam logic [7:0] OFF_ACC    = 8'h08;
  localparam logic [7:0] OFF_PWR    = 8'h0c;
  localparam logic [7:0] OFF_RES_LO = 8'h10;
  localparam logic [7:0] OFF_RES_HI = 8'h14;
  localparam logic [7:0] OFF_GT     = 8'h18;
  localparam logic [7:0] OFF_LT     = 8'h1c;

  localparam int CTRL_EN    = 7;
  localparam int CTRL_BURST = 6;
  localparam int CTRL_DONE  = 5;
  localparam int CTRL_BUSY  = 4;
  localparam int CTRL_WIN   = 3;
  localparam int CFG_DIV_LO = 3;
  localparam int CFG_EIGHT  = 2;
  localparam int CFG_TRACK  = 1;
  localparam int CFG_GAIN   = 0;
  localparam int ACC_TWELVE = 7;
  localparam int PWR_LOWPWR = 7;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'hf8;
  localparam logic [4:0] DIV_RESET  = 5'h1f;

  localparam logic [2:0] SRC_SOFT = 3'h0;
  localparam logic [2:0] SRC_T0   = 3'h1;
  localparam logic [2:0] SRC_T2   = 3'h2;
  localparam logic [2:0] SRC_T3   = 3'h3;

  localparam logic [3:0] LOW_BIT_FULL  = 4'h0;
  localparam logic [3:0] LOW_BIT_EIGHT = 4'h2;
  localparam logic [3:0] TOP_BIT       = 4'h9;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SARC_IDLE  = 2'b00,
    SARC_TRACK = 2'b01,
    SARC_CONV  = 2'b11,
    SARC_DONE  = 2'b10
  } sarc_state_t;

  // repeat field: 0..5 -> 1,4,8,16,32,64; other codes act as 64
  function automatic logic [6:0] sarc_repeat(input logic [2:0] f);
    unique case (f)
      3'h0:    sarc_repeat = 7'h01;
      3'h1:    sarc_repeat = 7'h04;
      3'h2:    sarc_repeat = 7'h08;
      3'h3:    sarc_repeat = 7'h10;
      3'h4:    sarc_repeat = 7'h20;
      default: sarc_repeat = 7'h40;
    endcase
  endfunction
endpackage

// ===== core/sarc_sar.sv
// successive-approximation sequencer: one track tick, then one
// decision per SAR clock; assumes the comparator is valid per tick
`timescale 1ns/1ns
`default_nettype none
module sarc_sar
  import sarc_pkg::*;
(
  input  wire logic    aclk,
  input  wire logic    aresetn,
  input  wire logic    ce,
  sarc_conv_if.core    cv
);
  sarc_state_t state_reg;
  logic [4:0]  div_reg;
  logic [3:0]  idx_reg;
  logic [9:0]  res;
  logic [9:0]  mask;
  logic [3:0]  stop;
  logic        tick;

  assign tick = (div_reg == cv.div);
  assign mask = 10'h001 << idx_reg;
  // unresolved low bits stay zero in the trial word
  assign stop = cv.eight ? LOW_BIT_EIGHT : LOW_BIT_FULL;
  assign res  = cv.cmp ? cv.trial : (cv.trial & ~mask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_reg <= 5'h00;
    else if (ce)
      div_reg <= (state_reg == SARC_IDLE || tick) ? 5'h00
                 : div_reg + 5'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= SARC_IDLE;
      idx_reg   <= TOP_BIT;
      cv.trial  <= 10'h000;
      cv.code   <= 10'h000;
      cv.sample <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_reg)
        SARC_IDLE:
          if (cv.go)
          begin
            state_reg <= SARC_TRACK;
            cv.sample <= 1'b1;
            cv.trial  <= 10'h000;
          end
        SARC_TRACK:
          if (tick)
          begin
            state_reg <= SARC_CONV;
            cv.sample <= 1'b0;
            idx_reg   <= TOP_BIT;
            cv.trial  <= 10'h200;
          end
        SARC_CONV:
          if (tick)
          begin
            // eight-bit stops two decisions earlier
            if (idx_reg == stop)
            begin
              cv.code   <= res;
              state_reg <= SARC_DONE;
            end
            else
            begin
              cv.trial <= res | (mask >> 1);
              idx_reg  <= idx_reg - 4'h1;
            end
          end
        SARC_DONE:
          state_reg <= SARC_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cv.done <= 1'b0;
      cv.busy <= 1'b0;
    end
    else if (ce)
    begin
      cv.done <= (state_reg == SARC_CONV) && tick && (idx_reg == stop);
      cv.busy <= (state_reg == SARC_IDLE) ? cv.go
                 : (state_reg != SARC_DONE);
    end
  end
endmodule
`default_nettype wire

// ===== core/sarc_top.sv
// converter control: registers on AXI4-Lite, start selection,
// burst accumulation, resolution modes and window compare
// assumes the analog core samples dac_trial and returns cmp_in
`timescale 1ns/1ns
`default_nettype none
module sarc_top
  import sarc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              timer0_overflow,
  input  wire logic              timer2_overflow,
  input  wire logic              timer3_overflow,
  input  wire logic              external_start_pin,
  input  wire logic              cmp_in,
  output var  logic              gain_select,
  output var  logic              low_power_bias_bit,
  output var  logic              converter_power,
  output wire logic              sample_hold,
  output wire logic [9:0]        dac_trial,
  output var  logic [1:0]        ref_select,
  output var  logic [1:0]        dem_select
);
  sarc_conv_if cv ();

  sarc_sar u_sar (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .cv      (cv)
  );

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a[1:0] == 2'b00) && (a <= OFF_LT);
  endfunction

  logic             en_reg, burst_reg, done_reg, win_reg;
  logic [2:0]       src_reg;
  logic [4:0]       div_reg;
  logic             eight_reg, track_reg;
  logic             twelve_reg;
  logic [2:0]       rpt_reg;
  logic [ACC_W-1:0] result_reg, gt_reg, lt_reg, acc_reg;
  logic [6:0]       cnt_reg, run_reg;
  logic             go_reg, ext_prev_reg;
  logic [ADDR_W-1:0] aw_reg;
  logic [31:0]      wd_reg;
  logic [3:0]       ws_reg;
  logic             aw_full, w_full;

  logic             wr_do, wr_ok, wr_ctrl, busy_write;
  logic             trig, start_ok, twelve_active, last_conv;
  logic [6:0]       target;
  logic [ACC_W-1:0] acc_sum, result_next;
  logic [7:0]       ctrl_view;

  assign sample_hold = cv.sample;
  assign dac_trial   = cv.trial;
  assign cv.cmp      = cmp_in;
  assign cv.go       = go_reg;
  assign cv.div      = div_reg;

  // twelve-bit only with burst and a repeat that is a multiple of four
  assign twelve_active = twelve_reg && burst_reg
                         && (rpt_reg != 3'h0);
  assign cv.eight = eight_reg && !twelve_active;
  assign target   = sarc_repeat(rpt_reg);

  // ---------------- AXI4-Lite write side
  assign wr_do = aw_full && w_full && !s_axi_bvalid;
  assign wr_ok = wr_do && reg_hit(aw_reg);
  assign wr_ctrl = wr_ok && (aw_reg == OFF_CTRL) && ws_reg[0];
  assign busy_write = wr_ctrl && wd_reg[CTRL_BUSY];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_reg        <= '0;
      wd_reg        <= 32'h0000_0000;
      ws_reg        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_full && !s_axi_awready;
      s_axi_wready  <= !w_full && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_hit(aw_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- register storage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_reg       <= CTRL_RESET[CTRL_EN];
      burst_reg    <= CTRL_RESET[CTRL_BURST];
      src_reg      <= CTRL_RESET[2:0];
      div_reg      <= DIV_RESET;
      eight_reg    <= CFG_RESET[CFG_EIGHT];
      track_reg    <= CFG_RESET[CFG_TRACK];
      gain_select  <= CFG_RESET[CFG_GAIN];
      twelve_reg   <= 1'b0;
      rpt_reg      <= 3'h0;
      low_power_bias_bit <= 1'b0;
      gt_reg       <= '0;
      lt_reg       <= '0;
    end
    else if (ce && wr_ok)
    begin
      unique case (aw_reg)
        OFF_CTRL:
          if (ws_reg[0])
          begin
            en_reg    <= wd_reg[CTRL_EN];
            burst_reg <= wd_reg[CTRL_BURST];
            src_reg   <= wd_reg[2:0];
          end
        OFF_CFG:
          if (ws_reg[0])
          begin
            div_reg     <= wd_reg[7:CFG_DIV_LO];
            eight_reg   <= wd_reg[CFG_EIGHT];
            track_reg   <= wd_reg[CFG_TRACK];
            gain_select <= wd_reg[CFG_GAIN];
          end
        OFF_ACC:
          if (ws_reg[0])
          begin
            twelve_reg <= wd_reg[ACC_TWELVE];
            rpt_reg    <= wd_reg[2:0];
          end
        OFF_PWR:
          if (ws_reg[0])
            low_power_bias_bit <= wd_reg[PWR_LOWPWR];
        OFF_GT:
        begin
          if (ws_reg[0]) gt_reg[7:0]  <= wd_reg[7:0];
          if (ws_reg[1]) gt_reg[15:8] <= wd_reg[15:8];
        end
        OFF_LT:
        begin
          if (ws_reg[0]) lt_reg[7:0]  <= wd_reg[7:0];
          if (ws_reg[1]) lt_reg[15:8] <= wd_reg[15:8];
        end
        default: ;
      endcase
    end
  end

  // ---------------- start selection
  always_comb
  begin
    unique casez (src_reg)
      SRC_SOFT: trig = busy_write;
      SRC_T0:   trig = timer0_overflow;
      SRC_T2:   trig = timer2_overflow;
      SRC_T3:   trig = timer3_overflow;
      default:  trig = external_start_pin && !ext_prev_reg;
    endcase
  end

  // in burst mode software and timer starts launch a whole burst; an external edge launches one conversion
  // a start while a run is pending is dropped
  assign start_ok = trig && (en_reg || burst_reg)
                    && (run_reg == 7'h00) && !cv.busy
                    && !go_reg;

  // ---------------- conversion sequencing and accumulation
  assign acc_sum   = acc_reg + {{(ACC_W-CODE_W){1'b0}}, cv.code};
  assign last_conv = (cnt_reg + 7'h01) == target;
  // sums of 10-bit codes: four give at most 4092, sixteen fit 14 bits
  assign result_next = cv.eight ? {acc_sum[9:2], 8'h00}
                       : acc_sum;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_prev_reg <= 1'b0;
    else if (ce)
      ext_prev_reg <= external_start_pin;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_reg <= 7'h00;
      go_reg  <= 1'b0;
    end
    else if (ce)
    begin
      // an external edge in burst mode still launches one conversion
      if (start_ok)
        run_reg <= (burst_reg && !src_reg[2]) ? target : 7'h01;
      else if (go_reg)
        run_reg <= run_reg - 7'h01;
      go_reg <= !go_reg && !cv.busy && (run_reg != 7'h00);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_reg    <= '0;
      cnt_reg    <= 7'h00;
      result_reg <= '0;
    end
    else if (ce)
    begin
      if (start_ok && cnt_reg == 7'h00)
        acc_reg <= '0;
      else if (cv.done)
      begin
        acc_reg <= acc_sum;
        if (last_conv)
        begin
          cnt_reg    <= 7'h00;
          result_reg <= result_next;
        end
        else
          cnt_reg <= cnt_reg + 7'h01;
      end
    end
  end

  // reference and element arrangement differ for each of four passes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_select      <= 2'h0;
      dem_select      <= 2'h0;
      converter_power <= 1'b0;
    end
    else if (ce)
    begin
      if (go_reg)
      begin
        ref_select <= twelve_active ? cnt_reg[1:0] : 2'h0;
        dem_select <= twelve_active ? {cnt_reg[0], ~cnt_reg[1]}
                      : 2'h0;
      end
      // in burst the core sleeps between runs unless enabled
      converter_power <= en_reg || cv.busy || go_reg
                         || (run_reg != 7'h00);
    end
  end

  // ---------------- sticky flags: hardware set beats software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_reg <= CTRL_RESET[CTRL_DONE];
      win_reg  <= CTRL_RESET[CTRL_WIN];
    end
    else if (ce)
    begin
      if (cv.done && last_conv)
        done_reg <= 1'b1;
      else if (wr_ctrl)
        done_reg <= wd_reg[CTRL_DONE];
      if (cv.done && last_conv && (result_next > gt_reg)
          && (result_next < lt_reg))
        win_reg <= 1'b1;
      else if (wr_ctrl)
        win_reg <= wd_reg[CTRL_WIN];
    end
  end

  // ---------------- AXI4-Lite read side
  assign ctrl_view = {en_reg, burst_reg, done_reg,
                      cv.busy || go_reg || (run_reg != 7'h00),
                      win_reg, src_reg};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        unique case (s_axi_araddr)
          OFF_CTRL:   s_axi_rdata <= {24'h0, ctrl_view};
          OFF_CFG:    s_axi_rdata <= {24'h0, div_reg, eight_reg,
                                      track_reg, gain_select};
          OFF_ACC:    s_axi_rdata <= {24'h0, twelve_reg, 4'h0, rpt_reg};
          OFF_PWR:    s_axi_rdata <= {24'h0, low_power_bias_bit, 7'h0};
          OFF_RES_LO: s_axi_rdata <= {24'h0, result_reg[7:0]};
          OFF_RES_HI: s_axi_rdata <= {24'h0, result_reg[15:8]};
          OFF_GT:     s_axi_rdata <= {16'h0, gt_reg};
          OFF_LT:     s_axi_rdata <= {16'h0, lt_reg};
          default:    s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/sarc_analog_model.sv
// behavioural analog core: track-and-hold plus ideal comparator
// assumes the bench gives the input level in converter codes
`timescale 1ns/1ns
`default_nettype none
module sarc_analog_model
(
  input  wire logic       aclk,
  input  wire logic       sample_hold,
  input  wire logic       gain_select,
  input  wire logic [9:0] dac_trial,
  input  wire logic [9:0] level,
  output var  logic       cmp_in
);
  logic [9:0] held = 10'h000;

  // half gain: full scale needs twice the input, so the code halves
  always_ff @(posedge aclk)
  begin
    if (sample_hold)
      held <= gain_select ? {1'b0, level[9:1]} : level;
  end

  always_comb
    cmp_in = held >= dac_trial;
endmodule
`default_nettype wire

// ===== tb/sarc_top_assertions.sv
// port checker for the converter control block
// assumes one aclk domain, bound onto sarc_top
`timescale 1ns/1ns
`default_nettype none
module sarc_chk
  import sarc_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              gain_select,
  input wire logic              low_power_bias_bit,
  input wire logic [1:0]        ref_select,
  input wire logic [1:0]        dem_select
);
  logic [7:0] aw_q;
  logic [7:0] ar_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a > 8'h1c || a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_q <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready)
      ar_q <= s_axi_araddr;
  end

  sequence wr_pair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  write_answer_a: assert property (
    wr_pair |-> ##[1:2] s_axi_bvalid)
    else $error("write got no response");
  read_answer_a: assert property (
    rd_take |-> ##1 s_axi_rvalid)
    else $error("read got no data");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  bresp_code_a: assert property (
    $rose(s_axi_bvalid) |-> s_axi_bresp == resp_of(aw_q))
    else $error("wrong write response");
  rresp_code_a: assert property (
    $rose(s_axi_rvalid) |-> s_axi_rresp == resp_of(ar_q)
    && (resp_of(ar_q) == RESP_OKAY || s_axi_rdata == 32'h0))
    else $error("wrong read response");
  reset_outputs_a: assert property (
    $rose(aresetn) |-> !gain_select && !low_power_bias_bit
    && ref_select == 2'h0 && dem_select == 2'h0)
    else $error("outputs not cleared by reset");
  gain_by_write_a: assert property (
    $past(aresetn) && $changed(gain_select) |-> s_axi_bvalid)
    else $error("gain changed without a write");
  bias_by_write_a: assert property (
    $past(aresetn) && $changed(low_power_bias_bit) |-> s_axi_bvalid)
    else $error("bias changed without a write");
endmodule

bind sarc_top sarc_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .gain_select(gain_select), .low_power_bias_bit(low_power_bias_bit),
  .ref_select(ref_select), .dem_select(dem_select));
`default_nettype wire

// ===== tb/test_sarc_top.sv
// self-checking bench for sarc_top over AXI4-Lite
// assumes the analog model answers with an ideal comparator
`timescale 1ns/1ns
`default_nettype none
module test_sarc_top;
  import sarc_pkg::*;
  logic        aclk, aresetn, awv, wv, bre, arv, rre, clr;
  logic        awr, wr, bv, arr, rv, gain, lpb, pwr, sh, cmp;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, d;
  logic [1:0]  br, rr, refs, dems, r;
  logic [3:0]  trig, dseen, rseen;
  logic [9:0]  lvl, trial;
  int          error_cnt, num_checks, cyc;

  sarc_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre),
    .timer0_overflow(trig[0]), .timer2_overflow(trig[1]),
    .timer3_overflow(trig[2]), .external_start_pin(trig[3]),
    .cmp_in(cmp), .gain_select(gain), .low_power_bias_bit(lpb),
    .converter_power(pwr), .sample_hold(sh), .dac_trial(trial),
    .ref_select(refs), .dem_select(dems));

  sarc_analog_model i_ana (.aclk(aclk), .sample_hold(sh),
    .gain_select(gain), .dac_trial(trial), .level(lvl), .cmp_in(cmp));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // records which reference and element arrangements were used
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    dseen <= clr ? 4'h0 : dseen | (4'h1 << dems);
    rseen <= clr ? 4'h0 : rseen | (4'h1 << refs);
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] er);
    logic ad, wdn;
    ad = 1'b0;
    wdn = 1'b0;
    awa <= a;
    wd <= v;
    {awv, wv} <= 2'b11;
    while (!(ad && wdn))
    begin
      @(posedge aclk);
      ad = ad || awr === 1'b1;
      wdn = wdn || wr === 1'b1;
      awv <= !ad;
      wv <= !wdn;
    end
    // the response is left waiting once so the hold check sees a stall
    do @(posedge aclk); while (bv !== 1'b1);
    bre <= 1'b1;
    do @(posedge aclk); while (bv !== 1'b1);
    bre <= 1'b0;
    chk(32'(br), 32'(er));
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
    ara <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    @(posedge aclk);
    rre <= 1'b1;
    do @(posedge aclk); while (rv !== 1'b1);
    v = rd;
    rs = rr;
    rre <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a, d, r);
    chk(d, e);
  endtask

  task automatic wait_done();
    do axr(OFF_CTRL, d, r); while (d[CTRL_DONE] !== 1'b1);
  endtask

  task automatic res(input logic [15:0] e);
    rchk(OFF_RES_HI, {24'h0, e[15:8]});
    rchk(OFF_RES_LO, {24'h0, e[7:0]});
  endtask

  task automatic pulse(input int i);
    trig[i] <= 1'b1;
    @(posedge aclk);
    trig[i] <= 1'b0;
    @(posedge aclk);
  endtask

  initial
  begin
    aresetn = 1'b0;
    {awv, wv, bre, arv, rre, clr} = 6'b000001;
    {awa, ara, wd, trig} = '0;
    {cyc, error_cnt, num_checks} = '0;
    lvl = 10'h2a5;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(OFF_CTRL, 32'h00);
    rchk(OFF_CFG, 32'hf8);
    axr(8'h20, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axw(8'h01, 32'hff, RESP_SLVERR);
    rchk(OFF_CTRL, 32'h00);
    $display("test 1 reset and map done");
    axw(OFF_GT, 32'h100, RESP_OKAY);
    axw(OFF_LT, 32'h200, RESP_OKAY);
    axw(OFF_CFG, 32'h01, RESP_OKAY);
    chk(32'(gain), 32'h1);
    axw(OFF_PWR, 32'h80, RESP_OKAY);
    chk(32'(lpb), 32'h1);
    rchk(OFF_PWR, 32'h80);
    clr <= 1'b0;
    // a start write is judged by the enable already stored
    axw(OFF_CTRL, 32'h80, RESP_OKAY);
    axw(OFF_CTRL, 32'h90, RESP_OKAY);
    wait_done();
    res(16'h0152);
    rchk(OFF_CTRL, 32'ha8);
    chk(32'(pwr), 32'h1);
    chk(32'(rseen), 32'h1);
    axw(OFF_CTRL, 32'h80, RESP_OKAY);
    rchk(OFF_CTRL, 32'h80);
    $display("test 2 gain, power and window done");
    axw(OFF_CFG, 32'h04, RESP_OKAY);
    axw(OFF_CTRL, 32'h90, RESP_OKAY);
    wait_done();
    res({lvl[9:2], 8'h00});
    rchk(OFF_CTRL, 32'ha0);
    $display("test 3 eight-bit done");
    lvl <= 10'h3ff;
    axw(OFF_CFG, 32'h00, RESP_OKAY);
    axw(OFF_ACC, 32'h81, RESP_OKAY);
    for (int s = 1; s <= 4; s++)
    begin
      clr <= 1'b1;
      axw(OFF_CTRL, 32'hc0 | 32'(s), RESP_OKAY);
      clr <= 1'b0;
      repeat (s == 4 ? 4 : 1)
      begin
        pulse(s - 1);
        // a start that lands while busy is dropped, so space them out
        repeat (40) @(posedge aclk);
      end
      wait_done();
      res(16'h0ffc);
      chk(32'(dseen), 32'hf);
      chk(32'(rseen), 32'hf);
    end
    $display("test 4 twelve-bit start sources done");
    axw(OFF_ACC, 32'h83, RESP_OKAY);
    // source back to software first: the start write sees the old source
    axw(OFF_CTRL, 32'hc0, RESP_OKAY);
    axw(OFF_CTRL, 32'hd0, RESP_OKAY);
    wait_done();
    res(16'h3ff0);
    axw(OFF_ACC, 32'h80, RESP_OKAY);
    axw(OFF_CTRL, 32'hd0, RESP_OKAY);
    wait_done();
    res(16'h03ff);
    $display("test 5 repeat counts done");
    end_of_test();
  end
endmodule
`default_nettype wire
